/* verilog/core_ops_pkg.sv */
// Constants, opcode patterns and helper functions for the byte-move and return execution unit
package core_ops_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;

  // Field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam int FADDR_LSB = 0;
  localparam int LIT_LSB = 0;

  // Reset values, data constants and the counter step
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  // Opcode masks and match values
  localparam logic [INSTR_W-1:0] BYTE_OP_MASK = 14'h3f00;
  localparam logic [INSTR_W-1:0] INC_FILE_VAL = 14'h0a00;
  localparam logic [INSTR_W-1:0] OR_FILE_VAL = 14'h0400;
  localparam logic [INSTR_W-1:0] MOVE_FILE_VAL = 14'h0800;
  localparam logic [INSTR_W-1:0] STORE_ACC_MASK = 14'h3f80;
  localparam logic [INSTR_W-1:0] STORE_ACC_VAL = 14'h0080;
  localparam logic [INSTR_W-1:0] IDLE_MASK = 14'h3f9f;
  localparam logic [INSTR_W-1:0] IDLE_VAL = 14'h0000;
  localparam logic [INSTR_W-1:0] LIT_OP_MASK = 14'h3c00;
  localparam logic [INSTR_W-1:0] LOAD_LIT_VAL = 14'h3000;
  localparam logic [INSTR_W-1:0] RET_LIT_VAL = 14'h3400;
  localparam logic [INSTR_W-1:0] IRQ_RET_MASK = 14'h3fff;
  localparam logic [INSTR_W-1:0] IRQ_RET_VAL = 14'h0009;

  typedef enum logic [3:0] {
    OP_BAD = 4'b0000,
    OP_INC_FILE = 4'b0001,
    OP_OR_FILE = 4'b0010,
    OP_MOVE_FILE = 4'b0011,
    OP_STORE_ACC = 4'b0100,
    OP_IDLE = 4'b0101,
    OP_LOAD_LIT = 4'b0110,
    OP_IRQ_RET = 4'b0111,
    OP_RET_LIT = 4'b1000
  } op_t;

  // Map an instruction word onto one of the supported operations
  function automatic op_t decode_op(input logic [INSTR_W-1:0] instr);
    op_t op;
    op = OP_BAD;
    if ((instr & IRQ_RET_MASK) == IRQ_RET_VAL) op = OP_IRQ_RET;
    else if ((instr & IDLE_MASK) == IDLE_VAL) op = OP_IDLE;
    else if ((instr & STORE_ACC_MASK) == STORE_ACC_VAL) op = OP_STORE_ACC;
    else if ((instr & BYTE_OP_MASK) == INC_FILE_VAL) op = OP_INC_FILE;
    else if ((instr & BYTE_OP_MASK) == OR_FILE_VAL) op = OP_OR_FILE;
    else if ((instr & BYTE_OP_MASK) == MOVE_FILE_VAL) op = OP_MOVE_FILE;
    else if ((instr & LIT_OP_MASK) == LOAD_LIT_VAL) op = OP_LOAD_LIT;
    else if ((instr & LIT_OP_MASK) == RET_LIT_VAL) op = OP_RET_LIT;
    return op;
  endfunction

  // True for the two stack returns
  function automatic logic is_return(input op_t op);
    return (op == OP_IRQ_RET) || (op == OP_RET_LIT);
  endfunction

  // Null test of an 8-bit result
  function automatic logic is_null(input logic [DATA_W-1:0] v);
    return v == DATA_ZERO;
  endfunction
endpackage

/* verilog/file_ram.sv */
// File register memory with synchronous write and registered read data
`timescale 1ns/1ns
`default_nettype none
module file_ram #(
  parameter int AW = 7,
  parameter int DW = 8,
  parameter int DEPTH = 128
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Read returns the old contents when the same location is written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* verilog/ret_stack.sv */
// Circular return-address stack with push and pop
`timescale 1ns/1ns
`default_nettype none
module ret_stack #(
  parameter int AW = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [AW-1:0] push_addr,
  input wire logic pop,
  output logic [AW-1:0] top
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  logic [AW-1:0] slot_r [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] ptr_nxt;
  logic [PW-1:0] base;

  // Pop first, then push into the freed slot
  assign base = pop ? ptr_r - PTR_ONE : ptr_r;
  assign ptr_nxt = push ? base + PTR_ONE : base;
  assign top = slot_r[ptr_r - PTR_ONE];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Slot storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      slot_r[base] <= push_addr;
    end
  end
endmodule
`default_nettype wire

/* verilog/byte_move_logic_return_ops.sv */
// Execution unit for file increment, OR, moves, literal load, idle and the two stack returns
// Notes on behaviour
// RULE1 - The file operand field addresses locations 0 to 127 and one target bit picks the destination.
// RULE2 - Target bit 0 sends a byte result to the accumulator, target bit 1 back to the file register.
// RULE3 - Increment adds one to the file register, writes the destination and touches only the null flag.
// RULE4 - OR combines accumulator and file register, writes the destination and updates the null flag.
// RULE5 - Move copies the file register to the destination and updates the null flag, a register test when the target is 1.
// RULE6 - Load literal puts the 8-bit immediate in the accumulator and leaves all flags alone.
// RULE7 - The code generator fills the unused bits of the load literal word with zeros.
// RULE8 - Interrupt return pops the stack top into the program counter and sets the global interrupt allow bit.
// RULE9 - Store accumulator copies the accumulator into file register 0 to 127 and leaves the flags alone.
// RULE10 - Return with literal loads the immediate into the accumulator and the popped stack top into the program counter.
// RULE11 - Return with literal takes two instruction cycles before the return target runs.
// RULE12 - A stack return pops into the program counter and takes two instruction cycles.
// RULE13 - Idle takes one cycle and only advances the program counter.
// RULE14 - Where the null flag is affected it is set for a zero result and cleared otherwise.
`timescale 1ns/1ns
`default_nettype none
module byte_move_logic_return_ops #(
  parameter int STACK_DEPTH = core_ops_pkg::STACK_DEPTH,
  parameter int FILE_DEPTH = core_ops_pkg::FILE_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input wire logic [core_ops_pkg::INSTR_W-1:0] INSTR,
  input wire logic PUSH_EN,
  input wire logic [core_ops_pkg::PC_W-1:0] PUSH_ADDR,
  input wire logic IRQ_ALLOW_CLEAR,
  output logic BUSY,
  output logic [core_ops_pkg::PC_W-1:0] PROGRAM_COUNTER,
  output logic [core_ops_pkg::DATA_W-1:0] ACC,
  output logic ZERO_FLAG,
  output logic GLOBAL_IRQ_ALLOW,
  output logic FILE_WE,
  output logic [core_ops_pkg::FADDR_W-1:0] FILE_ADDR,
  output logic [core_ops_pkg::DATA_W-1:0] FILE_WDATA,
  output logic BAD_OP
);
  localparam int DW = core_ops_pkg::DATA_W;
  localparam int AW = core_ops_pkg::FADDR_W;
  localparam int PW = core_ops_pkg::PC_W;
  localparam int IW = core_ops_pkg::INSTR_W;

  // Timing of one word through the unit:
  //   edge 0  the word is taken into the execute stage and its file operand is read
  //   cycle 1 the result is formed, from a forwarded write if one just committed
  //   edge 1  accumulator, null flag, counter and any file write commit together
  // Words may follow each other on every edge. A stack return raises the busy output
  // for its second cycle, so the word after it is taken one edge later and runs from
  // the popped return address; a word offered while busy is simply not taken.
  // Words that match no supported operation only step the counter and pulse the
  // bad-word output, which lets the surrounding core trap them if it wants to.
  // The file memory itself has no reset; software must write a register before use.

  // Pipeline and architectural registers
  logic busy_r;
  logic ex_valid_r;
  logic [IW-1:0] ex_instr_r;
  logic [PW-1:0] pc_r;
  logic [DW-1:0] acc_r;
  logic zero_r;
  logic irq_allow_r;
  logic fwe_r;
  logic [AW-1:0] faddr_r;
  logic [DW-1:0] fdata_r;
  logic bad_r;

  logic accept;
  logic accept_ret;
  core_ops_pkg::op_t in_op;
  core_ops_pkg::op_t ex_op;
  logic [AW-1:0] rd_addr;
  logic [AW-1:0] ex_faddr;
  logic ex_dest_file;
  logic [DW-1:0] ex_lit;
  logic [DW-1:0] ram_q;
  logic [DW-1:0] operand;
  logic [DW-1:0] inc_result;
  logic [DW-1:0] or_result;
  logic [DW-1:0] byte_result;
  logic byte_op;
  logic ret_op;
  logic [PW-1:0] stack_top;
  logic [PW-1:0] pc_nxt;
  logic [DW-1:0] acc_nxt;
  logic zero_nxt;
  logic irq_allow_nxt;
  logic fwe_nxt;

  // Operation matches and next values of the stage and write registers
  logic is_inc_op;
  logic is_or_op;
  logic is_move_op;
  logic is_store_op;
  logic is_bad_op;
  logic ex_valid_nxt;
  logic [IW-1:0] ex_instr_nxt;
  logic busy_nxt;
  logic [AW-1:0] faddr_nxt;
  logic [DW-1:0] fdata_nxt;
  logic [DW-1:0] fwdata;
  logic bad_nxt;

  // Intake: the cycle after a return is taken is the second return cycle
  assign accept = INSTR_VALID && !busy_r;
  assign in_op = core_ops_pkg::decode_op(INSTR);
  assign accept_ret = accept && core_ops_pkg::is_return(in_op); // [RULE11] [RULE12]
  assign rd_addr = INSTR[core_ops_pkg::FADDR_LSB +: AW]; // [RULE1]

  // Execute-stage field decode
  assign ex_op = core_ops_pkg::decode_op(ex_instr_r);
  assign ex_faddr = ex_instr_r[core_ops_pkg::FADDR_LSB +: AW]; // [RULE1] [RULE9]
  assign ex_dest_file = ex_instr_r[core_ops_pkg::DEST_BIT]; // [RULE1]
  assign ex_lit = ex_instr_r[core_ops_pkg::LIT_LSB +: DW];

  // Forward the write made at the edge the operand was read
  assign operand = (fwe_r && faddr_r == ex_faddr) ? fdata_r : ram_q;

  // Byte-oriented results
  assign inc_result = operand + core_ops_pkg::DATA_ONE; // [RULE3]
  assign or_result = acc_r | operand; // [RULE4]
  assign byte_result = (ex_op == core_ops_pkg::OP_INC_FILE) ? inc_result :
                       (ex_op == core_ops_pkg::OP_OR_FILE) ? or_result :
                       operand; // [RULE5]
  assign is_inc_op = ex_valid_r && ex_op == core_ops_pkg::OP_INC_FILE; // [RULE3]
  assign is_or_op = ex_valid_r && ex_op == core_ops_pkg::OP_OR_FILE; // [RULE4]
  assign is_move_op = ex_valid_r && ex_op == core_ops_pkg::OP_MOVE_FILE; // [RULE5]
  assign is_store_op = ex_valid_r && ex_op == core_ops_pkg::OP_STORE_ACC; // [RULE9]
  assign is_bad_op = ex_valid_r && ex_op == core_ops_pkg::OP_BAD;
  assign byte_op = is_inc_op || is_or_op || is_move_op;
  assign ret_op = ex_valid_r && core_ops_pkg::is_return(ex_op);

  // Program counter: returns load the popped top, other executed words step it, cycles with no word hold
  assign pc_nxt = ret_op ? stack_top :
                  ex_valid_r ? pc_r + core_ops_pkg::PC_STEP : pc_r; // [RULE8] [RULE10] [RULE13]

  // Accumulator destinations
  assign acc_nxt = (byte_op && !ex_dest_file) ? byte_result : // [RULE2]
                   (ex_valid_r && (ex_op == core_ops_pkg::OP_LOAD_LIT ||
                    ex_op == core_ops_pkg::OP_RET_LIT)) ? ex_lit : // [RULE6] [RULE10]
                   acc_r;

  // Null flag moves only for the byte-oriented group
  assign zero_nxt = byte_op ? core_ops_pkg::is_null(byte_result) : zero_r; // [RULE14] [RULE3]

  // Interrupt return wins over an outside clear in the same cycle
  assign irq_allow_nxt = (ex_valid_r && ex_op == core_ops_pkg::OP_IRQ_RET) ? 1'b1 : // [RULE8]
                         IRQ_ALLOW_CLEAR ? 1'b0 : irq_allow_r;

  // File write: byte ops with target 1, and every store
  assign fwe_nxt = (byte_op && ex_dest_file) || // [RULE2] [RULE5]
                   (ex_valid_r && ex_op == core_ops_pkg::OP_STORE_ACC); // [RULE9]

  file_ram #(
    .AW(AW),
    .DW(DW),
    .DEPTH(FILE_DEPTH)
  ) u_file_ram (
    .clk(REF_CLK),
    .we(fwe_nxt),
    .waddr(ex_faddr),
    .wdata(fwdata),
    .raddr(rd_addr),
    .rdata(ram_q)
  );

  ret_stack #(
    .AW(PW),
    .DEPTH(STACK_DEPTH)
  ) u_ret_stack (
    .clk(REF_CLK),
    .rst(RESET),
    .push(PUSH_EN),
    .push_addr(PUSH_ADDR),
    .pop(ret_op), // [RULE8] [RULE10] [RULE12]
    .top(stack_top)
  );

  // Next values of the stage and write registers
  assign ex_valid_nxt = accept;
  assign ex_instr_nxt = accept ? INSTR : ex_instr_r;
  assign busy_nxt = accept_ret; // [RULE11] [RULE12]
  assign fwdata = is_store_op ? acc_r : byte_result; // [RULE9]
  assign faddr_nxt = fwe_nxt ? ex_faddr : faddr_r;
  assign fdata_nxt = fwe_nxt ? fwdata : fdata_r;
  assign bad_nxt = is_bad_op;

  // Execute stage holds a taken word for one cycle
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ex_valid_r <= 1'b0;
    end else begin
      ex_valid_r <= ex_valid_nxt;
    end
  end

  // Executing word, held while no new word is taken
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ex_instr_r <= '0;
    end else begin
      ex_instr_r <= ex_instr_nxt;
    end
  end

  // Busy covers the second cycle of a stack return
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt; // [RULE11] [RULE12]
    end
  end

  // Program counter; idle and unknown words only step it
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pc_r <= core_ops_pkg::PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Accumulator
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      acc_r <= core_ops_pkg::ACC_RESET;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Null flag
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      zero_r <= 1'b0;
    end else begin
      zero_r <= zero_nxt;
    end
  end

  // Global interrupt allow bit
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      irq_allow_r <= 1'b0;
    end else begin
      irq_allow_r <= irq_allow_nxt;
    end
  end

  // File write strobe, one cycle per committed write
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      fwe_r <= 1'b0;
    end else begin
      fwe_r <= fwe_nxt;
    end
  end

  // Address of the last file write, also used for forwarding
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      faddr_r <= '0;
    end else begin
      faddr_r <= faddr_nxt;
    end
  end

  // Data of the last file write, also used for forwarding
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      fdata_r <= core_ops_pkg::DATA_ZERO;
    end else begin
      fdata_r <= fdata_nxt;
    end
  end

  // Pulse for a word that matched no supported operation
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      bad_r <= 1'b0;
    end else begin
      bad_r <= bad_nxt;
    end
  end

  // Every output comes straight from its register
  assign BUSY = busy_r;
  assign PROGRAM_COUNTER = pc_r;
  assign ACC = acc_r;
  assign ZERO_FLAG = zero_r;
  assign GLOBAL_IRQ_ALLOW = irq_allow_r;
  assign FILE_WE = fwe_r;
  assign FILE_ADDR = faddr_r;
  assign FILE_WDATA = fdata_r;
  assign BAD_OP = bad_r;
endmodule
`default_nettype wire

/* dv/ops_chk.sv */
// Assertion checker for the byte-move and return execution unit
`timescale 1ns/1ns
`default_nettype none
module ops_chk (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input wire logic [13:0] INSTR,
  input wire logic BUSY,
  input wire logic [7:0] ACC,
  input wire logic ZERO_FLAG,
  input wire logic GLOBAL_IRQ_ALLOW,
  input wire logic FILE_WE,
  input wire logic [6:0] FILE_ADDR,
  input wire logic [7:0] FILE_WDATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // Decode of the word taken at each edge
  wire logic take = INSTR_VALID && !BUSY;
  wire logic is_ld = take && INSTR[13:10] == 4'hc;
  wire logic is_rl = take && INSTR[13:10] == 4'hd;
  wire logic is_ir = take && INSTR == 14'h0009;
  wire logic is_st = take && INSTR[13:7] == 7'h01;
  wire logic is_inc = take && INSTR[13:8] == 6'h0a;
  wire logic is_idle = take && (INSTR & 14'h3f9f) == 14'h0000;
  sequence busy_pulse;
    BUSY ##1 !BUSY;
  endsequence
  property lit_p(ev);
    logic [7:0] k;
    (ev, k = INSTR[7:0]) |-> ##2 ACC == k;
  endproperty
  property st_p;
    logic [6:0] a;
    (is_st, a = INSTR[6:0]) |-> ##2 (FILE_WE && FILE_ADDR == a && FILE_WDATA == ACC);
  endproperty
  load_lit_a: assert property (lit_p(is_ld)) else $error("literal load missed");
  ret_lit_a: assert property (lit_p(is_rl)) else $error("return literal missed");
  irq_allow_a: assert property (is_ir |-> ##2 GLOBAL_IRQ_ALLOW) else $error("allow not set");
  ret_busy_a: assert property ((is_rl || is_ir) |=> busy_pulse) else $error("return timing");
  store_write_a: assert property (st_p) else $error("store write wrong");
  inc_zero_a: assert property (is_inc && INSTR[7] |-> ##2
    (FILE_WE && ZERO_FLAG == (FILE_WDATA == 8'h00))) else $error("zero flag wrong");
  file_dest_a: assert property (is_inc && INSTR[7] |-> ##2 $stable(ACC)) else $error("acc hit");
  acc_dest_a: assert property (is_inc && !INSTR[7] |-> ##2 !FILE_WE) else $error("file hit");
  idle_keep_a: assert property (is_idle |-> ##2 ($stable(ACC) && $stable(ZERO_FLAG) && !FILE_WE))
    else $error("idle changed state");
endmodule
bind byte_move_logic_return_ops ops_chk chk (.REF_CLK(REF_CLK), .RESET(RESET),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .BUSY(BUSY), .ACC(ACC), .ZERO_FLAG(ZERO_FLAG),
  .GLOBAL_IRQ_ALLOW(GLOBAL_IRQ_ALLOW), .FILE_WE(FILE_WE), .FILE_ADDR(FILE_ADDR),
  .FILE_WDATA(FILE_WDATA));
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench for the byte-move and return execution unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic REF_CLK, RESET, INSTR_VALID, PUSH_EN, IRQ_ALLOW_CLEAR;
  logic [13:0] INSTR;
  logic [12:0] PUSH_ADDR, PROGRAM_COUNTER, pc_m;
  logic BUSY, ZERO_FLAG, GLOBAL_IRQ_ALLOW, FILE_WE, BAD_OP, z_m, gie_m;
  logic [7:0] ACC, FILE_WDATA, acc_m, v;
  logic [6:0] FILE_ADDR, a;
  logic [7:0] mem [128];
  logic [12:0] stk [$];
  int n_errors = 0;
  int tests_run = 0;
  int kind;
  integer seed = 38;
  byte_move_logic_return_ops dut (.REF_CLK(REF_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .PUSH_EN(PUSH_EN), .PUSH_ADDR(PUSH_ADDR), .IRQ_ALLOW_CLEAR(IRQ_ALLOW_CLEAR),
    .BUSY(BUSY), .PROGRAM_COUNTER(PROGRAM_COUNTER), .ACC(ACC), .ZERO_FLAG(ZERO_FLAG),
    .GLOBAL_IRQ_ALLOW(GLOBAL_IRQ_ALLOW), .FILE_WE(FILE_WE), .FILE_ADDR(FILE_ADDR),
    .FILE_WDATA(FILE_WDATA), .BAD_OP(BAD_OP));
  // Clock
  initial begin
    REF_CLK = 0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Offer one word, let it retire, then compare against the model
  task automatic run(input int kind, input logic d, input logic [6:0] f, input logic [7:0] k);
    logic [13:0] w;
    logic [7:0] r;
    logic we;
    we = 0;
    r = 0;
    case (kind)
      0: w = {6'h0a, d, f};
      1: w = {6'h04, d, f};
      2: w = {6'h08, d, f};
      3: w = {7'h01, f};
      4: w = 14'h0000;
      5: w = {6'h30, k};
      6: w = {6'h34, k};
      7: w = 14'h0009;
      default: w = 14'h3f00;
    endcase
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b1;
    INSTR <= w;
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b0;
    INSTR <= 14'($random(seed));
    @(posedge REF_CLK);
    #1;
    pc_m = pc_m + 13'h0001;
    if (kind < 3) begin
      r = kind == 0 ? mem[f] + 8'h01 : kind == 1 ? (acc_m | mem[f]) : mem[f];
      z_m = r == 8'h00;
      if (d) begin
        mem[f] = r;
        we = 1;
      end else acc_m = r;
    end
    if (kind == 3) begin
      mem[f] = acc_m;
      r = acc_m;
      we = 1;
    end
    if (kind == 5 || kind == 6) acc_m = k;
    if (kind == 6 || kind == 7) pc_m = stk.pop_back();
    if (kind == 7) gie_m = 1;
    check("acc", ACC, acc_m);
    check("zero", ZERO_FLAG, z_m);
    check("pc", PROGRAM_COUNTER, pc_m);
    check("allow", GLOBAL_IRQ_ALLOW, gie_m);
    check("busy", BUSY, 1'b0);
    check("we", FILE_WE, we);
    if (we) begin
      check("addr", FILE_ADDR, f);
      check("wdata", FILE_WDATA, r);
    end
    check("bad", BAD_OP, kind == 8);
  endtask
  task automatic push(input logic [12:0] ad);
    @(posedge REF_CLK);
    PUSH_EN <= 1'b1;
    PUSH_ADDR <= ad;
    @(posedge REF_CLK);
    PUSH_EN <= 1'b0;
    PUSH_ADDR <= ~ad;
    stk.push_back(ad);
  endtask
  // Main sequence
  initial begin
    RESET = 1;
    INSTR_VALID = 0;
    INSTR = 0;
    PUSH_EN = 0;
    PUSH_ADDR = 0;
    IRQ_ALLOW_CLEAR = 0;
    acc_m = 0;
    z_m = 0;
    gie_m = 0;
    pc_m = 0;
    repeat (8) @(posedge REF_CLK);
    RESET <= 1'b0;
    #1;
    check("pc", PROGRAM_COUNTER, 13'h0000);
    $display("test reset done");
    run(5, 0, 0, 8'hff);
    run(3, 0, 7'h7f, 0);
    run(3, 0, 7'h00, 0);
    run(0, 1, 7'h7f, 0);
    run(2, 1, 7'h7f, 0);
    run(2, 0, 7'h00, 0);
    run(1, 0, 7'h7f, 0);
    run(4, 0, 0, 0);
    run(8, 0, 0, 0);
    $display("test corner done");
    // Store then increment of one register on consecutive edges needs the forwarded value
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b1;
    INSTR <= {7'h01, 7'h15};
    @(posedge REF_CLK);
    INSTR <= {6'h0a, 1'b0, 7'h15};
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b0;
    @(posedge REF_CLK);
    #1;
    mem[7'h15] = acc_m;
    acc_m = acc_m + 8'h01;
    z_m = acc_m == 8'h00;
    pc_m = pc_m + 13'h0002;
    check("acc", ACC, acc_m);
    check("zero", ZERO_FLAG, z_m);
    check("pc", PROGRAM_COUNTER, pc_m);
    $display("test forward done");
    push(13'h1abc);
    push(13'h0123);
    push(13'h0456);
    run(7, 0, 0, 0);
    @(posedge REF_CLK);
    IRQ_ALLOW_CLEAR <= 1'b1;
    @(posedge REF_CLK);
    #1;
    gie_m = 0;
    check("allow", GLOBAL_IRQ_ALLOW, gie_m);
    // Clear held across an interrupt return: the return's set wins in that cycle
    run(7, 0, 0, 0);
    @(posedge REF_CLK);
    IRQ_ALLOW_CLEAR <= 1'b0;
    #1;
    gie_m = 0;
    check("allow", GLOBAL_IRQ_ALLOW, gie_m);
    run(6, 0, 0, 8'h5a);
    $display("test return done");
    repeat (40) begin
      a = 7'($random(seed));
      v = 8'($random(seed));
      run(5, 0, 0, v);
      run(3, 0, a, 0);
      run(5, 0, 0, 8'($random(seed)));
      kind = $unsigned($random(seed)) % 3;
      run(kind, 1'($random(seed)), a, 0);
    end
    $display("test random done");
    finish_test();
  end
  // Guard against a hang
  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
